/* port_regs_pkg.sv */
`default_nettype none
package port_regs_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_CTL = 8'h35;
  localparam logic [7:0] IDX_CTL_ALIAS = 8'h55;
  localparam logic [7:0] IDX_LCD_CTL = 8'h60;
  localparam logic [7:0] IDX_PCG_MASK = 8'h61;
  localparam logic [7:0] IDX_PCG_CTL = 8'h62;
  // Per port tables, entry 0..3 = ports A, B, C, J.
  localparam logic [3:0][7:0] IDX_PIN = {8'h40, 8'h06, 8'h03, 8'h00};
  localparam logic [3:0][7:0] IDX_DIR = {8'h41, 8'h07, 8'h04, 8'h01};
  localparam logic [3:0][7:0] IDX_OUT = {8'h42, 8'h08, 8'h05, 8'h02};
  localparam logic [3:0][7:0] PORT_MASK = {8'h7f, 8'hff, 8'hff, 8'hff};
  localparam int unsigned PORT_J = 3;
  // Field positions.
  localparam int unsigned CTL_PULLUP_OFF_BIT = 4;
  localparam logic [7:0] CTL_WR_MASK = 8'hf3;
  localparam int unsigned LCD_ON_BIT = 0;
  localparam int unsigned LCD_LOW_POWER_BIT = 1;
  localparam int unsigned PCG_GROUP0_BIT = 0;
  // Reset values.
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [1:0] RST_LCD_CTL = 2'h0;
  localparam logic [7:0] RST_PCG_MASK = 8'h00;
  // Timing and bus constants.
  localparam int unsigned SYNC_STAGES_DEF = 2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RD_WAIT = 2'b10
  } bus_state_t;
endpackage
`default_nettype wire

/* pin_ctl_if.sv */
`default_nettype none
interface pin_ctl_if;
  logic lcd_on;
  logic lcd_low_power_sel;
  logic pinchg_group0_en;
  logic [7:0] pinchg_mask;
  logic [7:0] pullup_override_en;
  logic [7:0] pullup_override_val;
  logic [7:0] dir_override_en;
  logic [7:0] dir_override_val;
  logic [7:0] outval_override_en;
  logic [7:0] outval_override_val;
  logic [7:0] input_gate_override_en;
  logic [7:0] input_gate_override_val;
  modport ctl(
    output lcd_on, lcd_low_power_sel, pinchg_group0_en, pinchg_mask,
    input pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    input outval_override_en, outval_override_val,
    input input_gate_override_en, input_gate_override_val
  );
  modport ovr(
    input lcd_on, lcd_low_power_sel, pinchg_group0_en, pinchg_mask,
    output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    output outval_override_en, outval_override_val,
    output input_gate_override_en, input_gate_override_val
  );
endinterface
`default_nettype wire

/* pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned STAGES = port_regs_pkg::SYNC_STAGES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [STAGES-1:0][WIDTH-1:0] stage_q;

  if (STAGES < 2) begin : g_chk
    $error("pin_sync needs at least two stages");
  end

  // Only the next stage reads each flop, so metastability stays in the chain.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[STAGES-2:0], din};
    end
  end

  assign dout = stage_q[STAGES-1];

  sync_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, STAGES) |-> dout == $past(din, STAGES))
    else $error("synchroniser latency wrong");
endmodule
`default_nettype wire

/* lcd_pin_override.sv */
`default_nettype none
module lcd_pin_override (
  // Clock and reset, used only by checks
  input wire logic clk,
  input wire logic rst_n,
  // Control in, overrides out
  pin_ctl_if.ovr ifc
);
  localparam logic [7:0] SEG_MASK = port_regs_pkg::PORT_MASK[port_regs_pkg::PORT_J];

  // Segment pins lose pull-up and output drive to the LCD driver.
  assign ifc.pullup_override_en = {8{ifc.lcd_on}} & SEG_MASK;
  assign ifc.pullup_override_val = 8'h00;
  assign ifc.dir_override_en = {8{ifc.lcd_on}} & SEG_MASK;
  assign ifc.dir_override_val = 8'h00;
  // The port value is never taken over.
  assign ifc.outval_override_en = 8'h00;
  assign ifc.outval_override_val = 8'h00;
  // In low-power LCD mode a segment pin with pin change enabled has its input cut to save current.
  assign ifc.input_gate_override_en = ifc.pinchg_mask & SEG_MASK
    & {8{ifc.pinchg_group0_en & ifc.lcd_on & ifc.lcd_low_power_sel}};
  assign ifc.input_gate_override_val = 8'h00;

  gate_and_a: assert property (@(posedge clk) disable iff (!rst_n)
    ifc.input_gate_override_en[0] == (ifc.pinchg_mask[0] && ifc.pinchg_group0_en
      && ifc.lcd_on && ifc.lcd_low_power_sel))
    else $error("input gate override is not the four-way and");
  bit7_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ifc.pullup_override_en[7] && !ifc.dir_override_en[7]
      && !ifc.input_gate_override_en[7])
    else $error("port J bit 7 has an override");
endmodule
`default_nettype wire

/* gpio_port_top.sv */
// Decided for this implementation: register access over AHB-Lite.
`default_nettype none
module gpio_port_top #(
  parameter int unsigned SYNC_STAGES = port_regs_pkg::SYNC_STAGES_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pads, slice 0..3 = ports A, B, C, J
  input wire logic [3:0][7:0] pad_in,
  output logic [3:0][7:0] pad_out,
  output logic [3:0][7:0] pad_oe,
  output logic [3:0][7:0] pad_pullup,
  output logic [3:0][7:0] pad_input_en,
  // LCD segment driver and pin-change logic, port J
  output logic [6:0] port_j_seg_owned,
  output logic [7:0] port_j_pinchg_level
);
  if (SYNC_STAGES < 2) begin : g_chk
    $error("SYNC_STAGES must be at least two");
  end

  function automatic logic reg_hit(input logic ok, input logic [7:0] a, input logic [7:0] idx);
    reg_hit = ok && (a == idx);
  endfunction

  pin_ctl_if ctl_ifc ();

  // Bus state.
  port_regs_pkg::bus_state_t state_q;
  port_regs_pkg::bus_state_t state_d;
  logic [7:0] addr_q;
  logic addr_ok_q;
  logic wr_pend_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  // Control registers.
  logic [7:0] ctl_q;
  logic [1:0] lcd_ctl_q;
  logic [7:0] pcg_mask_q;
  logic pcg_en_q;
  logic [6:0] seg_own_q;
  logic [7:0] pinchg_q;

  wire logic [3:0][7:0] pin_sync_w;
  wire logic take = hsel && htrans[1] && hready;
  wire logic addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0)
    && (hsize == port_regs_pkg::HSIZE_WORD);
  // Writes commit at the end of their data phase; every read is held one
  // wait cycle, so a read that follows directly still sees the new value.
  wire logic wr_commit = wr_pend_q;
  wire logic [7:0] wdata = hwdata[7:0];
  wire logic hit_ctl = reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_CTL)
    || reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_CTL_ALIAS);
  wire logic hit_lcd = reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_LCD_CTL);
  wire logic hit_pcgm = reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_PCG_MASK);
  wire logic hit_pcgc = reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_PCG_CTL);
  wire logic pullup_off = ctl_q[port_regs_pkg::CTL_PULLUP_OFF_BIT];
  wire logic [4:0][7:0] rd_or;
  wire logic [7:0] rd_misc = (hit_ctl ? ctl_q : 8'h00)
    | (hit_lcd ? {6'h0, lcd_ctl_q} : 8'h00)
    | (hit_pcgm ? pcg_mask_q : 8'h00)
    | (hit_pcgc ? {7'h0, pcg_en_q} : 8'h00);

  assign ctl_ifc.lcd_on = lcd_ctl_q[port_regs_pkg::LCD_ON_BIT];
  assign ctl_ifc.lcd_low_power_sel = lcd_ctl_q[port_regs_pkg::LCD_LOW_POWER_BIT];
  assign ctl_ifc.pinchg_group0_en = pcg_en_q;
  assign ctl_ifc.pinchg_mask = pcg_mask_q;

  pin_sync #(
    .WIDTH(32),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din(pad_in),
    .dout(pin_sync_w)
  );

  lcd_pin_override u_ovr (
    .clk(hclk),
    .rst_n(hresetn),
    .ifc(ctl_ifc.ovr)
  );

  assign rd_or[0] = rd_misc;

  for (genvar p = 0; p < 4; p++) begin : g_port
    localparam logic [7:0] MASK = port_regs_pkg::PORT_MASK[p];
    logic [7:0] out_q;
    logic [7:0] dir_q;
    logic [7:0] drv_q;
    logic [7:0] oe_q;
    logic [7:0] pu_q;
    logic [7:0] ine_q;
    logic [7:0] pue;
    logic [7:0] puv;
    logic [7:0] doe;
    logic [7:0] dov;
    logic [7:0] voe;
    logic [7:0] vov;
    logic [7:0] ieoe;
    logic [7:0] ieov;
    if (p == port_regs_pkg::PORT_J) begin : g_ovr
      assign pue = ctl_ifc.pullup_override_en;
      assign puv = ctl_ifc.pullup_override_val;
      assign doe = ctl_ifc.dir_override_en;
      assign dov = ctl_ifc.dir_override_val;
      assign voe = ctl_ifc.outval_override_en;
      assign vov = ctl_ifc.outval_override_val;
      assign ieoe = ctl_ifc.input_gate_override_en;
      assign ieov = ctl_ifc.input_gate_override_val;
    end else begin : g_plain
      assign pue = 8'h00;
      assign puv = 8'h00;
      assign doe = 8'h00;
      assign dov = 8'h00;
      assign voe = 8'h00;
      assign vov = 8'h00;
      assign ieoe = 8'h00;
      assign ieov = 8'h00;
    end
    wire logic we_out = wr_commit && reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_OUT[p]);
    wire logic we_dir = wr_commit && reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_DIR[p]);
    wire logic we_pin = wr_commit && reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_PIN[p]);
    // Writing ones to the pin register flips the output bits.
    wire logic [7:0] out_d = we_out ? (wdata & MASK)
      : (we_pin ? ((out_q ^ wdata) & MASK) : out_q);
    wire logic [7:0] dir_d = we_dir ? (wdata & MASK) : dir_q;
    wire logic [7:0] pin_lv = pin_sync_w[p] & ine_q & MASK;
    wire logic [7:0] dir_eff = (doe & dov) | (~doe & dir_q);
    wire logic [7:0] pu_eff = (pue & puv)
      | (~pue & ~dir_q & out_q & {8{~pullup_off}});
    wire logic [7:0] drv_eff = (voe & vov) | (~voe & out_q);
    wire logic [7:0] ine_eff = (ieoe & ieov) | ~ieoe;
    wire logic [7:0] rd_part =
      (reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_PIN[p]) ? pin_lv : 8'h00)
      | (reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_DIR[p]) ? dir_q : 8'h00)
      | (reg_hit(addr_ok_q, addr_q, port_regs_pkg::IDX_OUT[p]) ? out_q : 8'h00);

    assign rd_or[p+1] = rd_or[p] | rd_part;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        out_q <= port_regs_pkg::RST_OUT;
        dir_q <= port_regs_pkg::RST_DIR;
      end else begin
        out_q <= out_d;
        dir_q <= dir_d;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        drv_q <= 8'h00;
        oe_q <= 8'h00;
        pu_q <= 8'h00;
        ine_q <= 8'hff;
      end else begin
        drv_q <= drv_eff;
        oe_q <= dir_eff;
        pu_q <= pu_eff;
        ine_q <= ine_eff;
      end
    end

    assign pad_out[p] = drv_q;
    assign pad_oe[p] = oe_q;
    assign pad_pullup[p] = pu_q;
    assign pad_input_en[p] = ine_q;
  end

  always_comb begin
    state_d = state_q;
    hrdata_d = hrdata_q;
    case (state_q)
      port_regs_pkg::BUS_IDLE: begin
        if (take && !hwrite) begin
          state_d = port_regs_pkg::BUS_RD_WAIT;
        end
      end
      port_regs_pkg::BUS_RD_WAIT: begin
        state_d = port_regs_pkg::BUS_IDLE;
        hrdata_d = {24'h0, rd_or[4]};
      end
      default: begin
        state_d = port_regs_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= port_regs_pkg::BUS_IDLE;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0;
      hresp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hreadyout_q <= (state_d == port_regs_pkg::BUS_IDLE);
      hrdata_q <= hrdata_d;
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      addr_ok_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr[9:2];
        addr_ok_q <= addr_ok;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= port_regs_pkg::RST_CTL;
      lcd_ctl_q <= port_regs_pkg::RST_LCD_CTL;
      pcg_mask_q <= port_regs_pkg::RST_PCG_MASK;
      pcg_en_q <= 1'b0;
    end else if (wr_commit) begin
      if (hit_ctl) begin
        ctl_q <= wdata & port_regs_pkg::CTL_WR_MASK;
      end
      if (hit_lcd) begin
        lcd_ctl_q <= wdata[1:0];
      end
      if (hit_pcgm) begin
        pcg_mask_q <= wdata & port_regs_pkg::PORT_MASK[port_regs_pkg::PORT_J];
      end
      if (hit_pcgc) begin
        pcg_en_q <= wdata[port_regs_pkg::PCG_GROUP0_BIT];
      end
    end
  end

  // Bit 0 feeds pin-change source 24 and is segment 35 while the LCD owns it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_own_q <= 7'h00;
      pinchg_q <= 8'h00;
    end else begin
      seg_own_q <= ctl_ifc.dir_override_en[6:0];
      pinchg_q <= pin_sync_w[port_regs_pkg::PORT_J] & g_port[3].ine_q
        & port_regs_pkg::PORT_MASK[port_regs_pkg::PORT_J];
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign port_j_seg_owned = seg_own_q;
  assign port_j_pinchg_level = pinchg_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence wr_out_a_s;
    take && hwrite && addr_ok && haddr[9:2] == port_regs_pkg::IDX_OUT[0];
  endsequence

  sequence rd_ctl_s;
    take && !hwrite && addr_ok && haddr[9:2] == port_regs_pkg::IDX_CTL;
  endsequence

  lcd_pullup_off_a: assert property (ctl_ifc.lcd_on |=> pad_pullup[3][6:0] == 7'h00)
    else $error("segment pin kept its pull-up");
  lcd_dir_in_a: assert property (ctl_ifc.lcd_on |=> pad_oe[3][6:0] == 7'h00)
    else $error("segment pin still drives");
  lcd_keeps_value_a: assert property (ctl_ifc.lcd_on |=> pad_out[3] == $past(g_port[3].out_q))
    else $error("port J value was overridden");
  segment_35_owner_a: assert property ($rose(ctl_ifc.lcd_on) |=> port_j_seg_owned[0])
    else $error("segment 35 not handed to LCD");
  pullup_global_a: assert property (pullup_off && !ctl_ifc.lcd_on |=> pad_pullup == '0)
    else $error("pull-up active while disabled");
  ctl_zero_bits_a: assert property (rd_ctl_s ##2 hreadyout |-> hrdata[3:2] == 2'h0)
    else $error("control bits 3:2 read nonzero");
  out_a_write_a: assert property (wr_out_a_s ##1 hready |=> g_port[0].out_q == $past(hwdata[7:0]))
    else $error("port A output write lost");
  dir_to_pad_a: assert property (g_port[1].we_dir |=> ##1 pad_oe[1] == $past(hwdata[7:0], 2))
    else $error("port B direction not on pad");

  // Register checks wait for the data phase to close, since a write only lands at its end.
  sequence wr_out_c_s;
    take && hwrite && addr_ok && haddr[9:2] == port_regs_pkg::IDX_OUT[2] ##1 hready;
  endsequence

  sequence wr_dir_c_s;
    take && hwrite && addr_ok && haddr[9:2] == port_regs_pkg::IDX_DIR[2] ##1 hready;
  endsequence

  sequence wr_ctl_alias_s;
    take && hwrite && addr_ok && haddr[9:2] == port_regs_pkg::IDX_CTL_ALIAS ##1 hready;
  endsequence

  // A read answers one cycle late; the word must hold the level seen when it was built.
  sequence rd_pin_a_s;
    take && !hwrite && addr_ok && haddr[9:2] == port_regs_pkg::IDX_PIN[0]
      ##1 !hreadyout ##1 hreadyout;
  endsequence

  out_c_write_a: assert property (wr_out_c_s |=> g_port[2].out_q == $past(hwdata[7:0]))
    else $error("port C output write lost");
  dir_c_write_a: assert property (wr_dir_c_s |=> g_port[2].dir_q == $past(hwdata[7:0]))
    else $error("port C direction write lost");
  ctl_alias_write_a: assert property (wr_ctl_alias_s |=>
    ctl_q == ($past(hwdata[7:0]) & port_regs_pkg::CTL_WR_MASK))
    else $error("control write through alias lost");
  pin_read_a: assert property (rd_pin_a_s |-> hrdata[7:0] == $past(pin_sync_w[0]))
    else $error("port A pin read not the synced level");
  bit7_pads_idle_a: assert property (
    !pad_oe[3][7] && !pad_out[3][7] && !pad_pullup[3][7])
    else $error("port J bit 7 pad is active");
  gate_to_pad_a: assert property (
    ctl_ifc.input_gate_override_en[0] |=> !pad_input_en[3][0])
    else $error("gated input still enabled at pad");
  seg_release_a: assert property (!ctl_ifc.lcd_on |=> port_j_seg_owned == 7'h00)
    else $error("segment pins kept while LCD off");
endmodule
`default_nettype wire

/* pad_model.sv */
`default_nettype none
module pad_model (
  // Clock
  input wire logic clk,
  // Block side
  input wire logic [3:0][7:0] pad_out,
  input wire logic [3:0][7:0] pad_oe,
  input wire logic [3:0][7:0] pad_pullup,
  // Outside world
  input wire logic [3:0][7:0] ext_val,
  input wire logic [3:0][7:0] ext_en,
  output logic [3:0][7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][7:0] float_q = 32'h0;
  // A pad that nobody drives or pulls flips every cycle, so it never passes for a stable level.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                  (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule
`default_nettype wire

/* port_regs_and_lcd_pin_override_tb.sv */
`default_nettype none
module port_regs_and_lcd_pin_override_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0][7:0] pad_in, pad_out, pad_oe, pad_pullup, pad_input_en, ext_val, ext_en;
  logic [6:0] port_j_seg_owned;
  logic [7:0] port_j_pinchg_level;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  gpio_port_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_input_en(pad_input_en),
    .port_j_seg_owned(port_j_seg_owned), .port_j_pinchg_level(port_j_pinchg_level));

  pad_model pads (.clk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  always #12.5 hclk = ~hclk;

  // The whole run needs well under a thousand cycles; this only cuts a hang short.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(idx, 1'b0, 8'h00, x);
    check(x, exp);
  endtask

  // Pad outputs follow one edge after the register; two spare edges keep it clear.
  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task automatic t_reset;
    for (int p = 0; p < 3; p++) begin
      rd_chk(port_regs_pkg::IDX_DIR[p], 32'h0);
      rd_chk(port_regs_pkg::IDX_OUT[p], 32'h0);
    end
    rd_chk(port_regs_pkg::IDX_CTL, 32'h0);
    check(pad_oe, 32'h0);
    check(pad_out, 32'h0);
  endtask

  task automatic t_regs;
    for (int p = 0; p < 3; p++) begin
      wr(port_regs_pkg::IDX_DIR[p], 8'h5a ^ 8'(p));
      wr(port_regs_pkg::IDX_OUT[p], 8'hc3 ^ 8'(p));
      settle;
      rd_chk(port_regs_pkg::IDX_DIR[p], {24'h0, 8'h5a ^ 8'(p)});
      rd_chk(port_regs_pkg::IDX_OUT[p], {24'h0, 8'hc3 ^ 8'(p)});
      check({24'h0, pad_oe[p]}, {24'h0, 8'h5a ^ 8'(p)});
      check({24'h0, pad_out[p]}, {24'h0, 8'hc3 ^ 8'(p)});
    end
    wr(port_regs_pkg::IDX_CTL, 8'hef);
    rd_chk(port_regs_pkg::IDX_CTL, 32'he3);
    rd_chk(port_regs_pkg::IDX_CTL_ALIAS, 32'he3);
    wr(port_regs_pkg::IDX_CTL_ALIAS, 8'h00);
    rd_chk(port_regs_pkg::IDX_CTL, 32'h0);
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 32'h0);
  endtask

  task automatic t_pullup;
    wr(port_regs_pkg::IDX_DIR[0], 8'h00);
    wr(port_regs_pkg::IDX_OUT[0], 8'hff);
    settle;
    check({24'h0, pad_pullup[0]}, 32'hff);
    rd_chk(port_regs_pkg::IDX_PIN[0], 32'hff);
    wr(port_regs_pkg::IDX_CTL, 8'h10);
    settle;
    check(pad_pullup, 32'h0);
    wr(port_regs_pkg::IDX_CTL, 8'h00);
    settle;
    check({24'h0, pad_pullup[0]}, 32'hff);
    wr(port_regs_pkg::IDX_PIN[0], 8'h0f);
    rd_chk(port_regs_pkg::IDX_OUT[0], 32'hf0);
  endtask

  task automatic t_pins;
    wr(port_regs_pkg::IDX_DIR[1], 8'h00);
    ext_val[1] <= 8'ha5;
    ext_en[1] <= 8'hff;
    settle;
    rd_chk(port_regs_pkg::IDX_PIN[1], 32'ha5);
    wr(port_regs_pkg::IDX_DIR[2], 8'hff);
    wr(port_regs_pkg::IDX_OUT[2], 8'h3c);
    settle;
    rd_chk(port_regs_pkg::IDX_PIN[2], 32'h3c);
  endtask

  task automatic t_lcd;
    logic [7:0] f_idx [4];
    logic [7:0] f_off [4];
    f_idx = '{port_regs_pkg::IDX_PCG_MASK, port_regs_pkg::IDX_PCG_CTL,
              port_regs_pkg::IDX_LCD_CTL, port_regs_pkg::IDX_LCD_CTL};
    f_off = '{8'h00, 8'h00, 8'h02, 8'h01};
    wr(port_regs_pkg::IDX_DIR[3], 8'hff);
    wr(port_regs_pkg::IDX_OUT[3], 8'hff);
    settle;
    rd_chk(port_regs_pkg::IDX_DIR[3], 32'h7f);
    check({24'h0, pad_oe[3]}, 32'h7f);
    wr(port_regs_pkg::IDX_LCD_CTL, 8'h01);
    settle;
    check({24'h0, pad_oe[3]}, 32'h0);
    check({24'h0, pad_out[3]}, 32'h7f);
    check({25'h0, port_j_seg_owned}, 32'h7f);
    wr(port_regs_pkg::IDX_DIR[3], 8'h00);
    settle;
    check({24'h0, pad_pullup[3]}, 32'h0);
    wr(port_regs_pkg::IDX_LCD_CTL, 8'h00);
    settle;
    check({24'h0, pad_pullup[3]}, 32'h7f);
    check({25'h0, port_j_seg_owned}, 32'h0);
    wr(port_regs_pkg::IDX_PCG_MASK, 8'hff);
    rd_chk(port_regs_pkg::IDX_PCG_MASK, 32'h7f);
    wr(port_regs_pkg::IDX_PCG_CTL, 8'h01);
    wr(port_regs_pkg::IDX_LCD_CTL, 8'h03);
    settle;
    check({24'h0, pad_input_en[3]}, 32'h80);
    for (int k = 0; k < 4; k++) begin
      wr(f_idx[k], f_off[k]);
      settle;
      check({24'h0, pad_input_en[3]}, 32'hff);
      wr(port_regs_pkg::IDX_PCG_MASK, 8'hff);
      wr(port_regs_pkg::IDX_PCG_CTL, 8'h01);
      wr(port_regs_pkg::IDX_LCD_CTL, 8'h03);
    end
    wr(port_regs_pkg::IDX_LCD_CTL, 8'h00);
    ext_val[3] <= 8'h81;
    ext_en[3] <= 8'hff;
    settle;
    check({24'h0, port_j_pinchg_level}, 32'h01);
    rd_chk(port_regs_pkg::IDX_PIN[3], 32'h01);
  endtask

  task automatic t_reset_mid;
    wr(port_regs_pkg::IDX_LCD_CTL, 8'h01);
    settle;
    check({25'h0, port_j_seg_owned}, 32'h7f);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    check(pad_pullup, 32'h0);
    check(pad_oe, 32'h0);
    check(pad_out, 32'h0);
    check(pad_input_en, 32'hffffffff);
    check({25'h0, port_j_seg_owned}, 32'h0);
    check({24'h0, port_j_pinchg_level}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(port_regs_pkg::IDX_DIR[3], 32'h0);
    rd_chk(port_regs_pkg::IDX_OUT[3], 32'h0);
    rd_chk(port_regs_pkg::IDX_CTL, 32'h0);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = port_regs_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    ext_val = 32'h0;
    ext_en = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_pullup;
    t_pins;
    t_lcd;
    t_reset_mid;
    end_sim;
  end
endmodule
`default_nettype wire
